// ==== design/cpp_pkg.sv ====
// Constants shared by both ends of the crosspoint programming port.
// Assumes both ends run on one 40 MHz system clock; the serial clock is a pin.
//
// Summary of operation
// - Mode pin low serial, high parallel.
// - Clock edges ignored while chip select high.
// - Host selects one device by chip select.
// - Serial bit shifted on each falling clock.
// - Full serial sequence is forty bits.
// - Eight slots: four-bit source, one enable bit.
// - Enable low disables output, source ignored.
// - Host sends highest output slot first.
// - Update latches transparent while strobe, select low.
// - Strobe high while shifting, then pulse low.
// - Serial out chains devices, 40 bits each.
// - Parallel write pin setup by host.
// - Parallel falling clock loads addressed slot only.
// - Parallel data applied only on update low.
// - Reset disables outputs, keeps register contents.
// - Host loads all slots before first update.
// - No select and update low before loading.
// - Index pins binary, lowest pin least significant.
package cpp_pkg;
    // ------------------------------------------------------------------
    // Matrix geometry
    // ------------------------------------------------------------------
    localparam int NUM_OUTPUTS = 8;   // Output slots in the matrix.
    localparam int SRC_BITS    = 4;   // Source index width.
    localparam int IDX_BITS    = 3;   // Output index width.
    localparam int SLOT_BITS   = 5;   // Source index plus output-on bit.
    localparam int CHAIN_BITS  = 40;  // Bits per device in a serial sequence.
    localparam int ON_POS      = 0;   // Output-on bit sits at slot LSB.
    localparam int SRC_POS     = 1;   // Source index sits above it.
    // ------------------------------------------------------------------
    // Host timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 40;   // System clock rate.
    localparam int HALF_PERIOD_NS = 200;  // Half period basis; host holds each serial clock half 9 cycles (225 ns).
    localparam int HALF_CYCLES    = (HALF_PERIOD_NS * CLK_MHZ) / 1000;
    // Host command register offsets.
    localparam logic [3:0] REG_CTRL   = 4'h0;  // Bit0 go, bit1 parallel, bit2 reset.
    localparam logic [3:0] REG_SLOT0  = 4'h1;  // Slots at 1..8 (5 bits each).
    localparam logic [3:0] REG_STATUS = 4'h9;  // Bit0 busy.
    localparam logic [3:0] REG_PSEL   = 4'hA;  // Parallel slot selected for write.
    localparam logic [3:0] REG_DOUT   = 4'hB;  // Captured serial output bits.
endpackage

// ==== design/cpp_if.sv ====
// Interface carrying the programming pins between host and crosspoint.
// Assumes both ends share the system clock; pins are asynchronous to it.
`timescale 1ns/1ps
interface cpp_if;
    logic       sclk;              // Serial/parallel clock, falling-edge active.
    logic       chip_sel_n;        // Active-low chip select.
    logic       update_n;          // Active-low update strobe.
    logic       load_mode_select;  // Low serial, high parallel.
    logic       reset_n;           // Active-low output disable reset.
    logic       data_in;           // Serial data into the device.
    logic       data_out;          // Serial data out of the device.
    logic [2:0] output_index;      // Parallel output address.
    logic [3:0] source_index;      // Parallel source index.
    logic       output_on;         // Parallel output-on bit.
    modport dev  (input sclk, chip_sel_n, update_n, load_mode_select, reset_n, data_in,
                  output_index, source_index, output_on, output data_out);
    modport host (output sclk, chip_sel_n, update_n, load_mode_select, reset_n, data_in,
                  output_index, source_index, output_on, input data_out);
endinterface

// ==== design/cpp_device.sv ====
// Crosspoint programming logic: shift register, update latches, output gating.
// Assumes all pins arrive asynchronously and are sampled by clk.
`timescale 1ns/1ps
module cpp_device (
    input  wire logic                                   clk,
    input  wire logic                                   reset,
    cpp_if.dev                                          pins,
    output logic [cpp_pkg::NUM_OUTPUTS*cpp_pkg::SRC_BITS-1:0] route_src,
    output logic [cpp_pkg::NUM_OUTPUTS-1:0]             route_en
);
    localparam int N = cpp_pkg::CHAIN_BITS;
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [11:0] s1_q, s2_q;  // Two stages for every control and data pin but source MSB and output-on.
    logic        sclk_prev_q; // Previous synchronised clock, for edge finding.
    // All pins pass two flops so metastability never reaches the logic.
    always_ff @(posedge clk) begin
        // Source MSB and output-on have their own pairs of flops below.
        s1_q <= {pins.sclk, pins.chip_sel_n, pins.update_n, pins.load_mode_select,
                 pins.reset_n, pins.data_in, pins.output_index, pins.source_index[2:0]};
        s2_q <= s1_q;
    end
    logic on_s1_q, on_s2_q;  // Output-on pin synchroniser.
    always_ff @(posedge clk) begin
        on_s1_q <= pins.output_on;
        on_s2_q <= on_s1_q;
    end
    wire       sclk_s = s2_q[11];
    wire       cs_n_s = s2_q[10];
    wire       upd_n_s = s2_q[9];
    wire       par_s  = s2_q[8];
    wire       rst_n_s = s2_q[7];
    wire       din_s  = s2_q[6];
    wire [2:0] idx_s  = s2_q[5:3];
    wire [2:0] src_lo = s2_q[2:0];
    always_ff @(posedge clk) begin
        sclk_prev_q <= sclk_s;
    end
    // Falling edge only counts while selected.
    wire fall = sclk_prev_q & ~sclk_s & ~cs_n_s;
    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    // Slot k occupies bits [5k+4:5k]; output-on is bit 5k, source MSB is 5k+4,
    // so shifting into bit 0 delivers source MSB first and output-on last,
    // and the first slot sent ends up highest (output 7).
    logic [N-1:0] shift_q;         // Not reset: contents survive the reset pin.
    logic [3:0]   src_pin;         // Full parallel source index from the pins.
    logic         pins_src_msb_q;  // MSB of source index, synchronised separately.
    logic         msb_s1_q;        // First stage for that MSB.
    // The MSB takes the same two stages as the low bits, so all four stay aligned.
    always_ff @(posedge clk) begin
        msb_s1_q       <= pins.source_index[3];
        pins_src_msb_q <= msb_s1_q;
    end
    // Reassemble the parallel source index from both synchronisers.
    always_comb begin
        src_pin = {pins_src_msb_q, src_lo};
    end
    // Shift or parallel load on a qualified falling clock.
    always_ff @(posedge clk) begin
        if (fall) begin
            if (!par_s) begin
                shift_q <= {shift_q[N-2:0], din_s};
            end else begin
                // Only the addressed slot changes.
                shift_q[idx_s*cpp_pkg::SLOT_BITS +: cpp_pkg::SLOT_BITS] <=
                    {src_pin, on_s2_q};
            end
        end
    end
    // Serial output is the far end, refreshed on every clk edge.
    always_ff @(posedge clk) begin
        pins.data_out <= shift_q[N-1];
    end
    // Bit N-1 is updated together with the shift, so data_out lags one clk.
    // ------------------------------------------------------------------
    // Update latches and outputs
    // ------------------------------------------------------------------
    logic [N-1:0] latch_q;  // Matrix program; random until first update.
    // Transparent while strobe and select low, so shifting leaks through.
    always_ff @(posedge clk) begin
        if (!upd_n_s && !cs_n_s) begin
            latch_q <= shift_q;
        end
    end
    // Reset only disables outputs; latch and shift contents are kept.
    always_ff @(posedge clk) begin
        for (int k = 0; k < cpp_pkg::NUM_OUTPUTS; k++) begin
            if (reset || !rst_n_s) begin
                // A disabled output connects no source, whatever the latch holds.
                route_en[k]         <= 1'b0;
                route_src[k*4 +: 4] <= 4'h0;
            end else begin
                route_en[k] <= latch_q[k*cpp_pkg::SLOT_BITS + cpp_pkg::ON_POS];
                // Disabled slots show source zero since the index is ignored.
                route_src[k*4 +: 4] <= latch_q[k*cpp_pkg::SLOT_BITS + cpp_pkg::ON_POS] ?
                    latch_q[k*cpp_pkg::SLOT_BITS + cpp_pkg::SRC_POS +: 4] : 4'h0;
            end
        end
    end
endmodule // cpp_device

// ==== design/cpp_host.sv ====
// Host controller that drives the crosspoint programming pins.
// Assumes software writes slot registers then sets go in the control register.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module cpp_host (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    cpp_if.host             pins
);
    localparam int N = cpp_pkg::CHAIN_BITS;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_LOW = 4'h2, ST_HIGH = 4'h4, ST_UPD = 4'h8
    } cpp_state_e;
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    cpp_state_e  state_q;            // Sequencer state.
    logic [4:0]  slot_q [8];         // Slot images, {source, on}.
    logic [2:0]  ctrl_q;             // Parallel mode, device reset.
    logic [2:0]  psel_q;             // Slot for a parallel write.
    logic [5:0]  bit_q;              // Bits still to send.
    logic [7:0]  tmr_q;              // Half-period timer.
    logic [7:0]  dout_q;             // Last bits seen on serial out.
    logic        go;                 // Start pulse from a control write.
    logic [N-1:0] image;             // Serial image, highest slot first.
    assign go = wr && addr == cpp_pkg::REG_CTRL && wdata[0] && state_q == ST_IDLE;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            image[k*5 +: 5] = {slot_q[k][4:1], slot_q[k][0]};
        end
    end
    // Software writes to configuration.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= 3'h0;
            psel_q <= 3'h0;
            for (int k = 0; k < 8; k++) slot_q[k] <= 5'h00;
        end else if (wr) begin
            if (addr == cpp_pkg::REG_CTRL) ctrl_q <= wdata[2:0];
            if (addr == cpp_pkg::REG_PSEL) psel_q <= wdata[2:0];
            if (addr >= cpp_pkg::REG_SLOT0 && addr <= 4'h8)
                slot_q[3'(addr - cpp_pkg::REG_SLOT0)] <= wdata[4:0];
        end
    end
    // Read data one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clk) begin
        if (reset) rdata <= 8'h00;
        else if (rd) begin
            case (addr)
                cpp_pkg::REG_CTRL:   rdata <= {5'h00, ctrl_q};
                cpp_pkg::REG_STATUS: rdata <= {7'h00, state_q != ST_IDLE};
                cpp_pkg::REG_PSEL:   rdata <= {5'h00, psel_q};
                cpp_pkg::REG_DOUT:   rdata <= dout_q;
                default: rdata <= (addr >= 4'h1 && addr <= 4'h8) ?
                    {3'h0, slot_q[3'(addr - 4'h1)]} : 8'h00;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------------
    // Clock idles high, strobe stays high during shifting, then one pulse.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            bit_q   <= 6'h00;
            tmr_q   <= 8'h00;
            pins.sclk <= 1'b1;
            pins.chip_sel_n <= 1'b1;
            pins.update_n   <= 1'b1;
            pins.data_in    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: if (go) begin
                    pins.chip_sel_n <= 1'b0;
                    // The mode comes from the write itself; ctrl_q still holds the old one.
                    bit_q  <= wdata[1] ? 6'd1 : 6'(N);
                    tmr_q  <= 8'(cpp_pkg::HALF_CYCLES);
                    pins.data_in <= image[N-1];
                    state_q <= ST_HIGH;
                end
                ST_HIGH: if (tmr_q == 8'h00) begin
                    pins.sclk <= 1'b0;
                    tmr_q <= 8'(cpp_pkg::HALF_CYCLES);
                    state_q <= ST_LOW;
                end else tmr_q <= tmr_q - 8'h01;
                ST_LOW: if (tmr_q == 8'h00) begin
                    pins.sclk <= 1'b1;
                    tmr_q <= 8'(cpp_pkg::HALF_CYCLES);
                    bit_q <= bit_q - 6'h01;
                    // After the last bit there is nothing left to present.
                    pins.data_in <= (bit_q > 6'h01) ? image[6'(bit_q - 6'h02)] : 1'b0;
                    if (bit_q == 6'h01) begin
                        pins.update_n <= 1'b0;
                        state_q <= ST_UPD;
                    end else state_q <= ST_HIGH;
                end else tmr_q <= tmr_q - 8'h01;
                ST_UPD: if (tmr_q == 8'h00) begin
                    pins.update_n <= 1'b1;
                    pins.chip_sel_n <= 1'b1;
                    state_q <= ST_IDLE;
                end else tmr_q <= tmr_q - 8'h01;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // Capture serial out on each rising clock, at the end of each low half, for chain checks.
    logic [1:0] dq_q;  // Synchroniser for serial out.
    always_ff @(posedge clk) begin
        dq_q <= {dq_q[0], pins.data_out};
        if (reset) dout_q <= 8'h00;
        else if (state_q == ST_LOW && tmr_q == 8'h00) dout_q <= {dout_q[6:0], dq_q[1]};
    end
    // Static pins follow the control, slot-select and slot registers.
    always_comb begin
        pins.load_mode_select = ctrl_q[1];
        pins.reset_n          = ~ctrl_q[2];
        pins.output_index     = psel_q;
        pins.source_index     = slot_q[psel_q][4:1];
        pins.output_on        = slot_q[psel_q][0];
    end
endmodule // cpp_host

// ==== tb/cpp_asserts.sv ====
// Checker for the programming pins shared by host and crosspoint.
// Assumes it watches the interface on the system clock, reset high.
`timescale 1ns/1ps
module cpp_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic chip_sel_n,
    input wire logic update_n,
    input wire logic load_mode_select,
    input wire logic data_out
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic       sclk_q;   // Serial clock one cycle back.
    logic [5:0] falls_q;  // Falling edges inside the open frame.
    logic [3:0] since_q;  // Cycles since the last fall, saturating.
    // Falls are counted only while selected, so stray edges show in the total.
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        if (reset || chip_sel_n) falls_q <= 6'h00;
        else if (sclk_q && !sclk) falls_q <= falls_q + 6'h01;
    end
    // Saturates so a long idle never wraps into a false recent edge.
    always_ff @(posedge clk) begin
        if (reset || (sclk_q && !sclk)) since_q <= 4'h0;
        else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // A strobe shorter than two cycles could slip past the pin synchronisers.
    sequence s_upd_pulse;
        (!update_n && !chip_sel_n)[*2] ##[1:20] update_n;
    endsequence
    property p_upd_pulse;
        $fell(update_n) |-> s_upd_pulse;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse malformed");
    property p_mode_hold;
        $fell(sclk) |-> $stable(load_mode_select) && !chip_sel_n;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode or select moved");
    property p_upd_hi_shift;
        $fell(sclk) |-> update_n;
    endproperty
    a_upd_hi_shift: assert property (p_upd_hi_shift) else $error("update low at clock");
    property p_upd_cs;
        !update_n |-> !chip_sel_n;
    endproperty
    a_upd_cs: assert property (p_upd_cs) else $error("update without select");
    property p_idle_hi;
        chip_sel_n |-> sclk && update_n;
    endproperty
    a_idle_hi: assert property (p_idle_hi) else $error("idle pins not high");
    property p_half;
        $fell(sclk) |-> (!sclk)[*8];
    endproperty
    a_half: assert property (p_half) else $error("serial clock low too short");
    property p_frame_40;
        $rose(chip_sel_n) && !$past(load_mode_select) |-> falls_q == 6'h28;
    endproperty
    a_frame_40: assert property (p_frame_40) else $error("serial frame length wrong");
    property p_par_one;
        $rose(chip_sel_n) && $past(load_mode_select) |-> falls_q == 6'h01;
    endproperty
    a_par_one: assert property (p_par_one) else $error("parallel edge count wrong");
    property p_dout;
        $changed(data_out) |-> since_q < 4'h8;
    endproperty
    a_dout: assert property (p_dout) else $error("serial out moved without clock");
endmodule // cpp_asserts

// ==== tb/test_crosspoint_program_port.sv ====
// Bench joining host and crosspoint ends through the shared interface.
// Assumes the host register map and timing of the package.
`timescale 1ns/1ps
module test_crosspoint_program_port;
    logic        clk = 1'b0;     // System clock, 25 ns.
    logic        reset = 1'b1;   // Synchronous reset.
    logic [3:0]  addr = 4'h0;    // Register address.
    logic [7:0]  wdata = 8'h00;  // Write data.
    logic        wr = 1'b0;      // Write strobe.
    logic        rd = 1'b0;      // Read strobe.
    logic [7:0]  rdata;          // Read data.
    logic [31:0] route_src;      // Device source per output.
    logic [7:0]  route_en;       // Device enable per output.
    logic [4:0]  slot_x [8];     // Expected {source, on} per output.
    logic [7:0]  st;             // Last register read: status, serial out or slot select.
    logic [4:0]  prev0;          // Slot 0 of the previous serial frame.
    logic [4:0]  prev1;          // Slot 1 of the previous serial frame.
    integer      seed = 32'hDEA4;
    int          err_total = 0;
    int          check_count = 0;
    cpp_if pins_if ();
    cpp_host i_cpp_host (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pins(pins_if));
    cpp_device i_cpp_device (.clk(clk), .reset(reset), .pins(pins_if),
        .route_src(route_src), .route_en(route_en));
    cpp_asserts i_cpp_asserts (.clk(clk), .reset(reset), .sclk(pins_if.sclk),
        .chip_sel_n(pins_if.chip_sel_n), .update_n(pins_if.update_n),
        .load_mode_select(pins_if.load_mode_select), .data_out(pins_if.data_out));
    // Clock generator.
    always #12.5 clk = ~clk;
    // Disabled outputs report source zero, so only enabled slots show a source.
    function automatic logic [39:0] expect_route();
        logic [39:0] r;
        r = 40'h0;
        for (int k = 0; k < 8; k++) begin
            r[32 + k] = slot_x[k][0];
            if (slot_x[k][0]) r[4*k +: 4] = slot_x[k][4:1];
        end
        return r;
    endfunction
    // Serial out trails the register, so the last eight captures end on the new first bit.
    function automatic logic [7:0] expect_dout(input logic [4:0] old0, input logic [4:0] old1);
        return {old1[1:0], old0, slot_x[7][4]};
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register read-back compare.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each bus task starts one edge later, so a strobe is never set twice in a step.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // Polls busy under a bound, then lets the routing registers settle.
    task automatic wait_idle();
        for (int n = 0; n < 400; n++) begin
            rd_reg(cpp_pkg::REG_STATUS, st);
            if (st[0] === 1'b0) begin
                repeat (6) @(posedge clk);
                return;
            end
        end
        err_total++;
        tally_and_finish();
    endtask
    task automatic load_one(input int k, input logic [4:0] v);
        slot_x[k] = v;
        wr_reg(cpp_pkg::REG_PSEL, 8'(k));
        wr_reg(cpp_pkg::REG_SLOT0 + 4'(k), {3'h0, v});
        wr_reg(cpp_pkg::REG_CTRL, 8'h03);
        wait_idle();
    endtask
    // Main sequence: serial loads, parallel loads, then both kinds of reset.
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk({route_en, route_src}, 40'h0);
        for (int t = 0; t < 4; t++) begin
            prev0 = slot_x[0];
            prev1 = slot_x[1];
            for (int k = 0; k < 8; k++)
                slot_x[k] = (t == 0) ? {4'(k * 2 + 1), 1'(k != 3)} : 5'($random(seed));
            for (int k = 0; k < 8; k++)
                wr_reg(cpp_pkg::REG_SLOT0 + 4'(k), {3'h0, slot_x[k]});
            wr_reg(cpp_pkg::REG_CTRL, 8'h01);
            wait_idle();
            chk({route_en, route_src}, expect_route());
            // The first frame pushes out unloaded contents, so it is not compared.
            if (t > 0) begin
                rd_reg(cpp_pkg::REG_DOUT, st);
                chk8(st, expect_dout(prev0, prev1));
            end
        end
        $display("test serial done");
        for (int k = 0; k < 8; k++) begin
            load_one(k, (k == 0) ? 5'h1E : 5'($random(seed)));
            chk({route_en, route_src}, expect_route());
            rd_reg(cpp_pkg::REG_PSEL, st);
            chk8(st, 8'(k));
        end
        wr_reg(4'hC, 8'h07);
        wait_idle();
        chk({route_en, route_src}, expect_route());
        $display("test parallel done");
        wr_reg(cpp_pkg::REG_CTRL, 8'h04);
        repeat (8) @(posedge clk);
        chk({route_en, route_src}, 40'h0);
        load_one(5, 5'($random(seed)));
        chk({route_en, route_src}, expect_route());
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk({route_en, route_src}, 40'h0);
        load_one(2, 5'h0B);
        chk({route_en, route_src}, expect_route());
        $display("test reset done");
        tally_and_finish();
    end
endmodule // test_crosspoint_program_port
